/* core/uemr_consts.svh */
// Named constants for the USB endpoint mode responder
`ifndef UEMR_CONSTS_SVH
`define UEMR_CONSTS_SVH

// Endpoint mode encodings
`define UEMR_MODE_DISABLE 4'h0
`define UEMR_MODE_NAK_INOUT 4'h1
`define UEMR_MODE_STATUS_OUT 4'h2
`define UEMR_MODE_STALL_INOUT 4'h3
`define UEMR_MODE_STATUS_IN 4'h6
`define UEMR_MODE_ACK_OUT_ST_IN 4'hB
`define UEMR_MODE_ACK_IN_ST_OUT 4'hF
`define UEMR_MODE_NAK_OUT 4'h8
`define UEMR_MODE_ACK_OUT 4'h9
`define UEMR_MODE_NAK_IN 4'hC
`define UEMR_MODE_ACK_IN 4'hD

// Packet length figures, counted with the two CRC bytes included
`define UEMR_MAX_LEN 4'hA
`define UEMR_ZLP_LEN 4'h2
`define UEMR_ZERO_CNT 4'h0

// Endpoint numbers and reset values
`define UEMR_EP_CTRL 2'h0
`define UEMR_EP_DATA1 2'h1
`define UEMR_EP_DATA2 2'h2
`define UEMR_EP_NONE 2'h3
`define UEMR_REG_RST 8'h00

`endif

/* core/uemr_pkg.sv */
// Types and shared helpers for the USB endpoint mode responder
`include "uemr_consts.svh"

package uemr_pkg;

  typedef enum logic [1:0] {TOK_SETUP, TOK_IN, TOK_OUT} uemr_tok_kind_t;

  typedef enum logic [2:0] {RSP_NONE, RSP_ACK, RSP_NAK, RSP_STALL, RSP_TX} uemr_rsp_kind_t;

  // Token with its data stage summary, one-cycle event from the packet layer
  typedef struct packed {
    logic valid;
    uemr_tok_kind_t kind;
    logic [1:0] ep;
    logic [3:0] len;
    logic dval;
    logic toggle;
  } uemr_tok_t;

  // End of an IN data stage: host handshake seen or not
  typedef struct packed {
    logic valid;
    logic acked;
  } uemr_hs_t;

  // Answer to the packet layer
  typedef struct packed {
    logic valid;
    uemr_rsp_kind_t kind;
    logic [1:0] ep;
    logic [3:0] count;
  } uemr_rsp_t;

  // Firmware write strobes
  typedef struct packed {
    logic mode_wr;
    logic cnt_wr;
    logic [1:0] ep;
    logic [7:0] data;
  } uemr_fw_t;

  typedef struct packed {
    logic setup_rx;
    logic in_rx;
    logic out_rx;
    logic ackd;
    logic [3:0] mode;
  } uemr_ctrl_mode_t;

  typedef struct packed {
    logic stall;
    logic rsvd;
    logic nak_ie;
    logic ackd;
    logic [3:0] mode;
  } uemr_data_mode_t;

  typedef struct packed {
    logic toggle;
    logic dval;
    logic [1:0] rsvd;
    logic [3:0] count;
  } uemr_cnt_t;

  // Data stage short enough and passing its check
  function automatic logic uemr_pkt_ok(input uemr_tok_t t);
    uemr_pkt_ok = t.dval && (t.len <= `UEMR_MAX_LEN);
  endfunction : uemr_pkt_ok

  // Accepted data stage: store toggle, valid flag and length
  function automatic uemr_cnt_t uemr_cnt_load(input uemr_tok_t t);
    uemr_cnt_t c;
    c = uemr_cnt_t'(`UEMR_REG_RST);
    c.toggle = t.toggle;
    c.dval = 1'b1;
    c.count = t.len;
    uemr_cnt_load = c;
  endfunction : uemr_cnt_load

endpackage : uemr_pkg

/* core/uemr_data_ep.sv */
// Answer decision for one data endpoint
`timescale 1ns/1ps
`include "uemr_consts.svh"

module uemr_data_ep
  import uemr_pkg::*;
(
  input wire uemr_pkg::uemr_data_mode_t mode_reg,
  input wire uemr_pkg::uemr_cnt_t cnt_reg,
  input wire logic tok_hit,
  input wire uemr_pkg::uemr_tok_t tok,
  input wire logic hs_hit,
  input wire logic hs_acked,
  output uemr_pkg::uemr_rsp_kind_t rsp_kind,
  output logic [3:0] rsp_count,
  output logic wait_hs,
  output logic eng_wr,
  output uemr_pkg::uemr_data_mode_t mode_new,
  output logic cnt_wr,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  // Pure decode; the main module owns every flip-flop
  always_comb
  begin
    rsp_kind = RSP_NONE;
    rsp_count = `UEMR_ZERO_CNT;
    wait_hs = 1'b0;
    eng_wr = 1'b0;
    mode_new = mode_reg;
    cnt_wr = 1'b0;
    irq = 1'b0;
    if (hs_hit && hs_acked && mode_reg.mode == `UEMR_MODE_ACK_IN)
    begin
      // Host took the data: fall back to NAK IN until refilled
      eng_wr = 1'b1;
      mode_new.mode = `UEMR_MODE_NAK_IN;
      mode_new.ackd = 1'b1;
      irq = 1'b1;
    end
    else if (tok_hit && tok.kind == TOK_OUT)
    begin
      // IN-only, disabled and reserved modes fall to the default: no answer to OUT there
      case (mode_reg.mode)
        `UEMR_MODE_NAK_OUT:
        begin
          if (uemr_pkt_ok(tok))
          begin
            rsp_kind = RSP_NAK;
            irq = mode_reg.nak_ie;
          end
        end
        `UEMR_MODE_ACK_OUT:
        begin
          if (uemr_pkt_ok(tok) && mode_reg.stall)
          begin
            rsp_kind = RSP_STALL;
            irq = 1'b1;
          end
          else if (uemr_pkt_ok(tok))
          begin
            rsp_kind = RSP_ACK;
            eng_wr = 1'b1;
            mode_new.mode = `UEMR_MODE_NAK_OUT;
            mode_new.ackd = 1'b1;
            cnt_wr = 1'b1;
            irq = 1'b1;
          end
        end
        default:
        begin
          rsp_kind = RSP_NONE;
        end
      endcase
    end
    else if (tok_hit && tok.kind == TOK_IN)
    begin
      case (mode_reg.mode)
        `UEMR_MODE_NAK_IN:
        begin
          rsp_kind = RSP_NAK;
          irq = mode_reg.nak_ie;
        end
        `UEMR_MODE_ACK_IN:
        begin
          if (mode_reg.stall)
          begin
            rsp_kind = RSP_STALL;
            irq = 1'b1;
          end
          else
          begin
            rsp_kind = RSP_TX;
            rsp_count = cnt_reg.count;
            wait_hs = 1'b1;
          end
        end
        default:
        begin
          rsp_kind = RSP_NONE;
        end
      endcase
    end
  end

endmodule : uemr_data_ep

/* core/uemr_top.sv */
// Endpoint mode responder: answers tokens for the control and two data endpoints
`timescale 1ns/1ps
`include "uemr_consts.svh"

module uemr_top
  import uemr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  uemr_pkg::uemr_tok_t tok_i,
  uemr_pkg::uemr_hs_t hs_i,
  uemr_pkg::uemr_fw_t fw_i,
  input wire logic buf_wr_req,
  output logic buf_wr_ok,
  output uemr_pkg::uemr_rsp_t rsp_o,
  output uemr_pkg::uemr_ctrl_mode_t ctrl_mode_o,
  output uemr_pkg::uemr_data_mode_t data1_mode_o,
  output uemr_pkg::uemr_data_mode_t data2_mode_o,
  output uemr_pkg::uemr_cnt_t [2:0] cnt_o,
  output logic [2:0] irq_o
);
  import uemr_pkg::*;

  typedef enum logic {ST_IDLE, ST_WAIT_HS} uemr_st_t;

  // Whole state of the block
  typedef struct packed {
    uemr_st_t st;
    logic [1:0] pend_ep;
    uemr_rsp_t rsp;
    uemr_ctrl_mode_t ctrl;
    uemr_data_mode_t dm1;
    uemr_data_mode_t dm2;
    uemr_cnt_t [2:0] cnt;
    logic [2:0] irq;
  } uemr_state_t;

  uemr_state_t s_q, s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Data endpoint decoders
  logic tok_hit1, tok_hit2;
  logic hs_hit1, hs_hit2;
  uemr_rsp_kind_t rk1, rk2;
  logic [3:0] rc1, rc2;
  logic wt1, wt2;
  logic ew1, ew2;
  uemr_data_mode_t nm1, nm2;
  logic cw1, cw2;
  logic iq1, iq2;

  // A handshake only counts for the endpoint whose IN data is outstanding
  assign tok_hit1 = tok_i.valid && tok_i.ep == `UEMR_EP_DATA1;
  assign tok_hit2 = tok_i.valid && tok_i.ep == `UEMR_EP_DATA2;
  assign hs_hit1 = hs_i.valid && s_q.st == ST_WAIT_HS && s_q.pend_ep == `UEMR_EP_DATA1;
  assign hs_hit2 = hs_i.valid && s_q.st == ST_WAIT_HS && s_q.pend_ep == `UEMR_EP_DATA2;

  uemr_data_ep u_data1 (
    .mode_reg(s_q.dm1),
    .cnt_reg(s_q.cnt[1]),
    .tok_hit(tok_hit1),
    .tok(tok_i),
    .hs_hit(hs_hit1),
    .hs_acked(hs_i.acked),
    .rsp_kind(rk1),
    .rsp_count(rc1),
    .wait_hs(wt1),
    .eng_wr(ew1),
    .mode_new(nm1),
    .cnt_wr(cw1),
    .irq(iq1)
  );

  uemr_data_ep u_data2 (
    .mode_reg(s_q.dm2),
    .cnt_reg(s_q.cnt[2]),
    .tok_hit(tok_hit2),
    .tok(tok_i),
    .hs_hit(hs_hit2),
    .hs_acked(hs_i.acked),
    .rsp_kind(rk2),
    .rsp_count(rc2),
    .wait_hs(wt2),
    .eng_wr(ew2),
    .mode_new(nm2),
    .cnt_wr(cw2),
    .irq(iq2)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control endpoint decode, written as a set of combinational results
  uemr_rsp_kind_t rk0;
  logic [3:0] rc0;
  logic wt0, ew0, cw0, iq0;
  uemr_ctrl_mode_t nm0;
  logic tok_hit0, hs_hit0;

  assign tok_hit0 = tok_i.valid && tok_i.ep == `UEMR_EP_CTRL;
  assign hs_hit0 = hs_i.valid && s_q.st == ST_WAIT_HS && s_q.pend_ep == `UEMR_EP_CTRL;

  always_comb
  begin
    rk0 = RSP_NONE;
    rc0 = `UEMR_ZERO_CNT;
    wt0 = 1'b0;
    ew0 = 1'b0;
    nm0 = s_q.ctrl;
    cw0 = 1'b0;
    iq0 = 1'b0;
    if (hs_hit0 && hs_i.acked)
    begin
      // Host acknowledged our IN data: record it and move on
      ew0 = 1'b1;
      nm0.in_rx = 1'b1;
      nm0.ackd = 1'b1;
      iq0 = 1'b1;
      if (s_q.ctrl.mode == `UEMR_MODE_ACK_IN_ST_OUT)
        nm0.mode = `UEMR_MODE_NAK_INOUT;
      else
        nm0.mode = `UEMR_MODE_STALL_INOUT;
    end
    else if (tok_hit0 && s_q.ctrl.mode != `UEMR_MODE_DISABLE)
    begin
      case (s_q.ctrl.mode)
        `UEMR_MODE_NAK_INOUT, `UEMR_MODE_STATUS_OUT, `UEMR_MODE_STALL_INOUT,
        `UEMR_MODE_STATUS_IN, `UEMR_MODE_ACK_OUT_ST_IN, `UEMR_MODE_ACK_IN_ST_OUT:
        begin
          case (tok_i.kind)
            TOK_SETUP:
            begin
              // Junk or overlong SETUP leaves no trace and no interrupt
              if (uemr_pkt_ok(tok_i))
              begin
                rk0 = RSP_ACK;
                ew0 = 1'b1;
                nm0.setup_rx = 1'b1;
                nm0.ackd = 1'b1;
                nm0.mode = `UEMR_MODE_NAK_INOUT;
                cw0 = 1'b1;
                iq0 = 1'b1;
              end
            end
            TOK_IN:
            begin
              if (s_q.ctrl.mode == `UEMR_MODE_NAK_INOUT)
                rk0 = RSP_NAK;
              else if (s_q.ctrl.mode == `UEMR_MODE_STALL_INOUT)
                rk0 = RSP_STALL;
              else if (s_q.ctrl.mode == `UEMR_MODE_STATUS_OUT)
              begin
                rk0 = RSP_STALL;
                ew0 = 1'b1;
                nm0.mode = `UEMR_MODE_STALL_INOUT;
                iq0 = 1'b1;
              end
              else if (s_q.ctrl.mode == `UEMR_MODE_ACK_IN_ST_OUT)
              begin
                rk0 = RSP_TX;
                rc0 = s_q.cnt[0].count;
                wt0 = 1'b1;
              end
              else
              begin
                rk0 = RSP_TX;
                wt0 = 1'b1;
              end
            end
            default:
            begin
              // OUT: only a well formed data stage gets any answer
              if (!uemr_pkt_ok(tok_i))
                rk0 = RSP_NONE;
              else if (s_q.ctrl.mode == `UEMR_MODE_NAK_INOUT)
                rk0 = RSP_NAK;
              else if (s_q.ctrl.mode == `UEMR_MODE_STALL_INOUT)
                rk0 = RSP_STALL;
              else if (s_q.ctrl.mode == `UEMR_MODE_ACK_OUT_ST_IN)
              begin
                rk0 = RSP_ACK;
                ew0 = 1'b1;
                nm0.out_rx = 1'b1;
                nm0.ackd = 1'b1;
                nm0.mode = `UEMR_MODE_NAK_INOUT;
                cw0 = 1'b1;
                iq0 = 1'b1;
              end
              else if (s_q.ctrl.mode == `UEMR_MODE_STATUS_IN)
              begin
                rk0 = RSP_STALL;
                ew0 = 1'b1;
                nm0.mode = `UEMR_MODE_STALL_INOUT;
                iq0 = 1'b1;
              end
              else if (tok_i.len == `UEMR_ZLP_LEN && tok_i.toggle)
              begin
                // Good status stage: zero data bytes with toggle 1
                rk0 = RSP_ACK;
                ew0 = 1'b1;
                nm0.out_rx = 1'b1;
                nm0.ackd = 1'b1;
                nm0.mode = `UEMR_MODE_STATUS_OUT;
                cw0 = 1'b1;
                iq0 = 1'b1;
              end
              else
              begin
                rk0 = RSP_STALL;
                ew0 = 1'b1;
                nm0.mode = `UEMR_MODE_STALL_INOUT;
                iq0 = 1'b1;
              end
            end
          endcase
        end
        default:
        begin
          rk0 = RSP_NONE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state: answer, handshake wait, registers and firmware writes
  logic data_upd;

  // One shared update strobe covers both data mode registers, so an
  // engine write to either one locks out firmware on both
  assign data_upd = ew1 || ew2;

  always_comb
  begin
    s_d = s_q;
    s_d.rsp.valid = 1'b0;
    s_d.rsp.kind = RSP_NONE;
    s_d.rsp.count = `UEMR_ZERO_CNT;

    // A handshake, or a fresh token, closes any outstanding IN
    if (hs_i.valid || tok_i.valid)
      s_d.st = ST_IDLE;

    // Only one of the three decoders fires for any token
    if (tok_i.valid)
    begin
      s_d.rsp.ep = tok_i.ep;
      s_d.rsp.valid = (rk0 != RSP_NONE) || (rk1 != RSP_NONE) || (rk2 != RSP_NONE);
      if (tok_hit0)
      begin
        s_d.rsp.kind = rk0;
        s_d.rsp.count = rc0;
      end
      else if (tok_hit1)
      begin
        s_d.rsp.kind = rk1;
        s_d.rsp.count = rc1;
      end
      else if (tok_hit2)
      begin
        s_d.rsp.kind = rk2;
        s_d.rsp.count = rc2;
      end
      if (wt0 || wt1 || wt2)
      begin
        s_d.st = ST_WAIT_HS;
        s_d.pend_ep = tok_i.ep;
      end
    end

    // Firmware writes come first so that engine writes below override them
    if (fw_i.mode_wr && fw_i.ep == `UEMR_EP_CTRL && !ew0)
    begin
      // Sticky flags are cleared by any write and can never be set by one
      s_d.ctrl.mode = fw_i.data[3:0];
      s_d.ctrl.in_rx = 1'b0;
      s_d.ctrl.out_rx = 1'b0;
      s_d.ctrl.ackd = 1'b0;
      s_d.ctrl.setup_rx = 1'b0;
    end
    if (fw_i.mode_wr && fw_i.ep == `UEMR_EP_DATA1 && !data_upd)
    begin
      s_d.dm1 = uemr_data_mode_t'(fw_i.data);
      s_d.dm1.ackd = 1'b0;
    end
    if (fw_i.mode_wr && fw_i.ep == `UEMR_EP_DATA2 && !data_upd)
    begin
      s_d.dm2 = uemr_data_mode_t'(fw_i.data);
      s_d.dm2.ackd = 1'b0;
    end
    if (fw_i.cnt_wr && fw_i.ep != `UEMR_EP_NONE)
      s_d.cnt[fw_i.ep] = uemr_cnt_t'(fw_i.data);

    // Engine writes: take precedence over firmware, sets beat clears
    if (ew0)
      s_d.ctrl = nm0;
    if (ew1)
      s_d.dm1 = nm1;
    if (ew2)
      s_d.dm2 = nm2;
    if (cw0)
      s_d.cnt[0] = uemr_cnt_load(tok_i);
    if (cw1)
      s_d.cnt[1] = uemr_cnt_load(tok_i);
    if (cw2)
      s_d.cnt[2] = uemr_cnt_load(tok_i);

    // Endpoint interrupt pulses
    s_d.irq = {iq2, iq1, iq0};
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_q.st <= ST_IDLE;
      s_q.pend_ep <= `UEMR_EP_CTRL;
      s_q.rsp <= '0;
      s_q.ctrl <= uemr_ctrl_mode_t'(`UEMR_REG_RST);
      s_q.dm1 <= uemr_data_mode_t'(`UEMR_REG_RST);
      s_q.dm2 <= uemr_data_mode_t'(`UEMR_REG_RST);
      s_q.cnt <= '0;
      s_q.irq <= 3'h0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  // Buffer write grant is a plain gate: a SETUP landing this cycle is not
  // yet reflected, so firmware may see one extra granted cycle
  assign buf_wr_ok = buf_wr_req && !s_q.ctrl.setup_rx;
  assign rsp_o = s_q.rsp;
  assign ctrl_mode_o = s_q.ctrl;
  assign data1_mode_o = s_q.dm1;
  assign data2_mode_o = s_q.dm2;
  assign cnt_o = s_q.cnt;
  assign irq_o = s_q.irq;

endmodule : uemr_top

/* verif/uemr_properties.sv */
// Concurrent checks on the endpoint mode responder ports
`timescale 1ns/1ps

module uemr_properties
  import uemr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  uemr_pkg::uemr_tok_t tok_i,
  uemr_pkg::uemr_hs_t hs_i,
  input wire logic buf_wr_req,
  input wire logic buf_wr_ok,
  uemr_pkg::uemr_rsp_t rsp_o,
  uemr_pkg::uemr_ctrl_mode_t ctrl_mode_o,
  uemr_pkg::uemr_data_mode_t data1_mode_o,
  uemr_pkg::uemr_cnt_t [2:0] cnt_o,
  input wire logic [2:0] irq_o
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////////
  // Counted IN on the first data endpoint, then the host handshake
  sequence s_in_sent;
    tok_i.valid && tok_i.kind == TOK_IN && tok_i.ep == 2'h1 && data1_mode_o.mode == 4'hD
      && !data1_mode_o.stall ##1 rsp_o.valid && rsp_o.kind == RSP_TX;
  endsequence
  sequence s_host_ack;
    hs_i.valid && hs_i.acked;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  a_off_silent: assert property (
    tok_i.valid && tok_i.ep == 2'h0 && ctrl_mode_o.mode == 4'h0 |=> !rsp_o.valid)
    else $error("disabled control endpoint answered");
  a_setup_ack: assert property (
    tok_i.valid && tok_i.kind == TOK_SETUP && tok_i.ep == 2'h0 && tok_i.dval
      && tok_i.len <= 4'hA && ctrl_mode_o.mode inside {4'h1, 4'h2, 4'h3, 4'h6, 4'hB, 4'hF}
      |=> rsp_o.valid && rsp_o.kind == RSP_ACK && rsp_o.ep == 2'h0
      && ctrl_mode_o.mode == 4'h1 && ctrl_mode_o.setup_rx && irq_o[0])
    else $error("good setup not taken");
  a_bad_quiet: assert property (
    tok_i.valid && tok_i.kind != TOK_IN && (!tok_i.dval || tok_i.len > 4'hA) |=> !rsp_o.valid)
    else $error("bad data packet answered");
  a_buf_block: assert property (
    buf_wr_ok == (buf_wr_req && !ctrl_mode_o.setup_rx))
    else $error("buffer write gate wrong");
  a_ctrl_stall: assert property (
    tok_i.valid && tok_i.kind == TOK_IN && tok_i.ep == 2'h0 && ctrl_mode_o.mode == 4'h3
      |=> rsp_o.valid && rsp_o.kind == RSP_STALL && !irq_o[0] && $stable(ctrl_mode_o))
    else $error("stall mode IN not stalled");
  a_out_ack_back: assert property (
    tok_i.valid && tok_i.kind == TOK_OUT && tok_i.ep == 2'h1 && tok_i.dval
      && tok_i.len <= 4'hA && data1_mode_o.mode == 4'h9 && !data1_mode_o.stall
      |=> rsp_o.valid && rsp_o.kind == RSP_ACK && data1_mode_o.mode == 4'h8)
    else $error("out ack or fall back missing");
  a_out_stall: assert property (
    tok_i.valid && tok_i.kind == TOK_OUT && tok_i.ep == 2'h1 && tok_i.dval
      && tok_i.len <= 4'hA && data1_mode_o.mode == 4'h9 && data1_mode_o.stall
      |=> rsp_o.valid && rsp_o.kind == RSP_STALL)
    else $error("stalled out not stalled");
  a_nak_in_irq: assert property (
    tok_i.valid && tok_i.kind == TOK_IN && tok_i.ep == 2'h1 && data1_mode_o.mode == 4'hC
      |=> rsp_o.valid && rsp_o.kind == RSP_NAK && irq_o[1] == data1_mode_o.nak_ie)
    else $error("nak in or its interrupt wrong");
  a_in_count: assert property (
    s_in_sent |-> rsp_o.count == cnt_o[1].count)
    else $error("reply length differs from count field");
  a_in_handback: assert property (
    s_in_sent ##1 s_host_ack |=> data1_mode_o.mode == 4'hC && irq_o[1])
    else $error("acked IN did not fall back");
  a_reserved: assert property (
    tok_i.valid && tok_i.ep == 2'h1 && data1_mode_o.mode inside {4'h5, 4'h7, 4'hA}
      |=> !rsp_o.valid)
    else $error("reserved mode answered");
endmodule : uemr_properties

/* verif/uemr_host_model.sv */
// Host-side model issuing low-speed tokens and IN handshakes
`timescale 1ns/1ps

module uemr_host_model
  import uemr_pkg::*;
(
  input wire logic clk,
  output uemr_pkg::uemr_tok_t tok_o,
  output uemr_pkg::uemr_hs_t hs_o
);
  int junk = 87403;

  // Idle fields carry fresh junk so a stale token can never look right
  task automatic idle;
    tok_o = uemr_tok_t'($random(junk));
    tok_o.valid = 1'b0;
    hs_o = uemr_hs_t'($random(junk));
    hs_o.valid = 1'b0;
  endtask : idle

  initial
  begin
    idle();
  end

  ////////////////////////////////////////
  // One-cycle token, launched after a falling edge
  task automatic send_tok(input uemr_tok_kind_t k, input logic [1:0] e,
    input logic [3:0] l, input logic v, input logic g);
    @(negedge clk);
    tok_o = '{valid: 1'b1, kind: k, ep: e, len: l, dval: v, toggle: g};
    @(negedge clk);
    idle();
  endtask : send_tok

  // Handshake closing an IN data stage; acked low stands for a timeout
  task automatic send_hs(input logic a);
    @(negedge clk);
    hs_o = '{valid: 1'b1, acked: a};
    @(negedge clk);
    idle();
  endtask : send_hs
endmodule : uemr_host_model

/* verif/tb_usb_endpoint_mode_responder.sv */
// Self-checking bench for the endpoint mode responder
`timescale 1ns/1ps

module tb_usb_endpoint_mode_responder;
  import uemr_pkg::*;
  logic clk;
  logic rst_b;
  uemr_tok_t tok;
  uemr_hs_t hs;
  uemr_fw_t fw;
  logic buf_wr_req;
  logic buf_wr_ok;
  uemr_rsp_t rsp;
  uemr_ctrl_mode_t cmode;
  uemr_data_mode_t d1mode;
  uemr_data_mode_t d2mode;
  uemr_cnt_t [2:0] cnt;
  logic [2:0] irq;
  logic [9:0] exp_q[$];
  int failures = 0;
  int n_compared = 0;
  int seed = 87403;
  logic [3:0] cr;
  logic [3:0] l;
  logic [3:0] rsv [5] = '{4'h4, 4'h5, 4'h7, 4'hA, 4'hE};
  logic [3:0] cms [6] = '{4'h1, 4'h2, 4'h3, 4'h6, 4'hB, 4'hF};

  uemr_top uemr_top_i (.clk(clk), .rst_b(rst_b), .tok_i(tok), .hs_i(hs), .fw_i(fw),
    .buf_wr_req(buf_wr_req), .buf_wr_ok(buf_wr_ok), .rsp_o(rsp), .ctrl_mode_o(cmode),
    .data1_mode_o(d1mode), .data2_mode_o(d2mode), .cnt_o(cnt), .irq_o(irq));
  uemr_host_model uemr_host_model_i (.clk(clk), .tok_o(tok), .hs_o(hs));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////
  task automatic chk(input logic [23:0] seen, input logic [23:0] want);
    n_compared++;
    if (seen !== want)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : chk

  task automatic summarize;
    $display("compared %0d, mismatched %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  // Firmware write strobe for one cycle: mode register or count register
  task automatic fwr(input logic m, input logic [1:0] e, input logic [7:0] d);
    @(negedge clk);
    fw = '{mode_wr: m, cnt_wr: !m, ep: e, data: d};
    @(negedge clk);
    fw.mode_wr = 1'b0;
    fw.cnt_wr = 1'b0;
  endtask : fwr

  // Note the expected answer, then let the host send the token
  task automatic t(input uemr_tok_kind_t k, input logic [1:0] e, input logic [3:0] ln,
    input logic v, input logic g, input uemr_rsp_kind_t rk, input logic [3:0] c,
    input logic i);
    repeat (2) @(negedge clk);
    if (rk != RSP_NONE)
      exp_q.push_back({rk, e, c, i});
    uemr_host_model_i.send_tok(k, e, ln, v, g);
  endtask : t

  // Control endpoint case: fresh count, mode, then one token
  task automatic cm(input logic [3:0] m, input uemr_tok_kind_t k, input logic [3:0] ln,
    input logic g, input uemr_rsp_kind_t rk, input logic [3:0] c, input logic i);
    fwr(1'b0, 2'h0, {4'h0, cr});
    fwr(1'b1, 2'h0, {4'h0, m});
    t(k, 2'h0, ln, 1'b1, g, rk, c, i);
  endtask : cm

  function automatic logic [3:0] dmo(input int e);
    return (e == 1) ? d1mode.mode : d2mode.mode;
  endfunction : dmo

  ////////////////////////////////////////
  // Every answer is matched with the oldest note; count only matters for data
  always @(negedge clk)
  begin
    if (rst_b === 1'b1 && rsp.valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk({rsp.kind, rsp.ep, rsp.count}, 24'hFFFFFF);
      else
        chk({rsp.kind, rsp.ep, (rsp.kind == RSP_TX) ? rsp.count : 4'h0, irq[rsp.ep]},
          exp_q.pop_front());
    end
  end

  // Cut a hang short well past the expected run length
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    summarize();
  end

  initial
  begin
    rst_b = 1'b0;
    fw = '0;
    buf_wr_req = 1'b0;
    cr = 4'($unsigned($random(seed)) % 9);
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    chk({cmode, d1mode, d2mode}, 24'h0);
    for (int k = 0; k < 3; k++)
      t(uemr_tok_kind_t'(k), 2'h0, 4'h2, 1'b1, 1'b1, RSP_NONE, 4'h0, 1'b0);
    foreach (rsv[j])
    begin
      fwr(1'b1, 2'h0, {4'h0, rsv[j]});
      fwr(1'b1, 2'h1, {4'h0, rsv[j]});
      t(TOK_SETUP, 2'h0, 4'h4, 1'b1, 1'b0, RSP_NONE, 4'h0, 1'b0);
      t(uemr_tok_kind_t'(j % 3), 2'h1, 4'h2, 1'b1, 1'b1, RSP_NONE, 4'h0, 1'b0);
    end
    done("silent modes");
    cm(4'hF, TOK_IN, 4'h2, 1'b0, RSP_TX, cr, 1'b0);
    cm(4'hF, TOK_OUT, 4'h2, 1'b1, RSP_ACK, 4'h0, 1'b1);
    chk({cmode.mode, cnt[0].count}, {4'h2, 4'h2});
    cm(4'hF, TOK_OUT, 4'h2, 1'b0, RSP_STALL, 4'h0, 1'b1);
    cm(4'h1, TOK_IN, 4'h2, 1'b1, RSP_NAK, 4'h0, 1'b0);
    cm(4'h1, TOK_OUT, 4'h4, 1'b1, RSP_NAK, 4'h0, 1'b0);
    cm(4'h2, TOK_IN, 4'h2, 1'b1, RSP_STALL, 4'h0, 1'b1);
    cm(4'h2, TOK_OUT, 4'h2, 1'b1, RSP_ACK, 4'h0, 1'b1);
    cm(4'h2, TOK_OUT, 4'h5, 1'b1, RSP_STALL, 4'h0, 1'b1);
    cm(4'h3, TOK_IN, 4'h2, 1'b1, RSP_STALL, 4'h0, 1'b0);
    cm(4'h3, TOK_OUT, 4'h4, 1'b1, RSP_STALL, 4'h0, 1'b0);
    cm(4'h6, TOK_IN, 4'h2, 1'b1, RSP_TX, 4'h0, 1'b0);
    cm(4'h6, TOK_OUT, 4'h4, 1'b1, RSP_STALL, 4'h0, 1'b1);
    cm(4'hB, TOK_IN, 4'h2, 1'b1, RSP_TX, 4'h0, 1'b0);
    cm(4'hB, TOK_OUT, 4'h6, 1'b0, RSP_ACK, 4'h0, 1'b1);
    done("control modes");
    foreach (cms[j])
    begin
      l = 4'(2 + $unsigned($random(seed)) % 9);
      buf_wr_req = 1'b1;
      cm(cms[j], TOK_SETUP, l, l[0], RSP_ACK, 4'h0, 1'b1);
      chk({cmode, cnt[0].toggle, cnt[0].dval, cnt[0].count, buf_wr_ok},
        {8'h91, l[0], 1'b1, l, 1'b0});
    end
    t(TOK_SETUP, 2'h0, 4'hB, 1'b1, 1'b0, RSP_NONE, 4'h0, 1'b0);
    t(TOK_SETUP, 2'h0, 4'h4, 1'b0, 1'b0, RSP_NONE, 4'h0, 1'b0);
    fwr(1'b1, 2'h0, 8'h0B);
    t(TOK_OUT, 2'h0, 4'hB, 1'b1, 1'b0, RSP_NONE, 4'h0, 1'b0);
    chk({cmode.setup_rx, buf_wr_ok}, 2'b01);
    done("setup");
    for (int e = 1; e < 3; e++)
    begin
      for (int ie = 0; ie < 2; ie++)
      begin
        fwr(1'b1, 2'(e), {2'b00, 1'(ie), 5'h08});
        t(TOK_OUT, 2'(e), 4'h4, 1'b1, 1'b0, RSP_NAK, 4'h0, 1'(ie));
        t(TOK_IN, 2'(e), 4'h2, 1'b1, 1'b0, RSP_NONE, 4'h0, 1'b0);
        t(TOK_SETUP, 2'(e), 4'h2, 1'b1, 1'b0, RSP_NONE, 4'h0, 1'b0);
        fwr(1'b1, 2'(e), {2'b00, 1'(ie), 5'h0C});
        t(TOK_IN, 2'(e), 4'h2, 1'b1, 1'b0, RSP_NAK, 4'h0, 1'(ie));
        t(TOK_OUT, 2'(e), 4'h2, 1'b1, 1'b0, RSP_NONE, 4'h0, 1'b0);
      end
      l = 4'(2 + $unsigned($random(seed)) % 9);
      fwr(1'b1, 2'(e), 8'h09);
      t(TOK_OUT, 2'(e), l, 1'b1, 1'b0, RSP_ACK, 4'h0, 1'b1);
      chk({dmo(e), cnt[e]}, {4'h8, 4'h4, l});
      fwr(1'b1, 2'(e), 8'h89);
      t(TOK_OUT, 2'(e), l, 1'b1, 1'b0, RSP_STALL, 4'h0, 1'b1);
      fwr(1'b0, 2'(e), {4'h0, cr});
      fwr(1'b1, 2'(e), 8'h0D);
      t(TOK_IN, 2'(e), 4'h2, 1'b1, 1'b0, RSP_TX, cr, 1'b0);
      uemr_host_model_i.send_hs(1'b0);
      chk(dmo(e), 4'hD);
      t(TOK_IN, 2'(e), 4'h2, 1'b1, 1'b0, RSP_TX, cr, 1'b0);
      uemr_host_model_i.send_hs(1'b1);
      chk({dmo(e), irq[e]}, {4'hC, 1'b1});
      fwr(1'b1, 2'(e), 8'h8D);
      t(TOK_IN, 2'(e), 4'h2, 1'b1, 1'b0, RSP_STALL, 4'h0, 1'b1);
    end
    done("data modes");
    fwr(1'b1, 2'h1, 8'h09);
    fwr(1'b1, 2'h2, 8'h08);
    fork
      t(TOK_OUT, 2'h1, 4'h4, 1'b1, 1'b0, RSP_ACK, 4'h0, 1'b1);
      begin
        repeat (2) @(negedge clk);
        fwr(1'b1, 2'h2, 8'h0C);
      end
    join
    chk({d1mode.mode, d2mode.mode}, 8'h88);
    done("write clash");
    repeat (4) @(negedge clk);
    chk(24'(exp_q.size()), 24'h0);
    summarize();
  end
endmodule : tb_usb_endpoint_mode_responder

// Checker watches the top ports directly
bind uemr_top uemr_properties uemr_properties_i (.clk(clk), .rst_b(rst_b), .tok_i(tok_i),
  .hs_i(hs_i), .buf_wr_req(buf_wr_req), .buf_wr_ok(buf_wr_ok), .rsp_o(rsp_o),
  .ctrl_mode_o(ctrl_mode_o), .data1_mode_o(data1_mode_o), .cnt_o(cnt_o), .irq_o(irq_o));
